// >>> include/sofl_pkg.sv
// Contract
// R1 - Set end-overwrite flag of addressed endpoint at SETUP handshake phase.
// R2 - Set end-overwrite flag after every SETUP packet, even when already set.
// R3 - Firmware clears end-overwrite flag before reading FIFO after SETUP.
// R4 - While end-overwrite set, FIFO byte count and read pointer stay locked; code locks only the read pointer, and host writes still step byte count.
// R5 - Stale reads before the clear cannot move the read pointer.
// R6 - SETUP token sets start flag, resets FIFO state; clears at handshake end.
// R7 - Sequence bit written only with sequence-overwrite set; firmware reads back.
// R8 - Status shows endpoint picked by index register; all bits zero at reset.
package sofl_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_EP   = 4;
  localparam int EP_W     = 2;
  localparam int PTR_W    = 6;
  localparam int DAT_W    = 32;
  localparam int ADR_W    = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'hE2;
  localparam logic [ADR_W-1:0] ADDR_INDEX  = 8'hE4;
  localparam logic [ADR_W-1:0] ADDR_IRQST  = 8'hE8;
  localparam logic [ADR_W-1:0] ADDR_IRQMSK = 8'hEC;
  localparam logic [ADR_W-1:0] ADDR_FIFO   = 8'hF0;

  // Status register bit positions
  localparam int BIT_SEQ  = 7;
  localparam int BIT_STRT = 5;
  localparam int BIT_END  = 4;
  localparam int BIT_SOVW = 3;

  // Interrupt status bit positions
  localparam int IRQ_SETUP = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_W     = 2;

  localparam logic [7:0]       STATUS_RST = 8'h00;
  localparam logic [DAT_W-1:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [PTR_W-1:0] PTR_ZERO   = 6'h00;
  localparam logic [PTR_W-1:0] PTR_ONE    = 6'h01;
endpackage

// >>> verif/sofl_setup_lock_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sofl_setup_lock_assertions (
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic                        clkEn,
  input wire logic [sofl_pkg::EP_W-1:0]   usbEp,
  input wire logic                        usbSetupTok,
  input wire logic                        usbSetupHs,
  input wire logic [sofl_pkg::NUM_EP-1:0] epIsCtrl,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [sofl_pkg::ADR_W-1:0]  wb_adr_i,
  input wire logic [sofl_pkg::DAT_W-1:0]  wb_dat_i,
  input wire logic [sofl_pkg::DAT_W-1:0]  wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic                        wb_err_o,
  input wire logic [sofl_pkg::NUM_EP-1:0] fifoLocked
);
  default clocking @(posedge sys_clk); endclocking
  // Frozen cycles hold every answer back, so they are not judged
  default disable iff (!rst_n || !clkEn);
  logic req;
  logic mapped;
  logic clrHit;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i inside {sofl_pkg::ADDR_STATUS, sofl_pkg::ADDR_INDEX,
    sofl_pkg::ADDR_IRQST, sofl_pkg::ADDR_IRQMSK, sofl_pkg::ADDR_FIFO};
  // Status write clearing the end flag, at the edge where it lands
  assign clrHit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
    && wb_adr_i == sofl_pkg::ADDR_STATUS && !wb_dat_i[sofl_pkg::BIT_END];
  chk_ack_next_edge: assert property (req |=> wb_ack_o != wb_err_o)
    else $error("bus answer missing");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_err_unmapped: assert property (req && !mapped |=> wb_err_o)
    else $error("unmapped access not refused");
  chk_read_upper_zero: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper bits set");
  chk_token_locks: assert property (
    usbSetupTok && usbEp == 2'h0 && epIsCtrl[0] |-> ##2 fifoLocked[0])
    else $error("no start lock");
  chk_handshake_locks: assert property (
    usbSetupHs && usbEp == 2'h0 && epIsCtrl[0] |-> ##2 fifoLocked[0])
    else $error("no end lock");
  chk_plain_ep_free: assert property (
    usbSetupTok && usbEp == 2'h1 && !epIsCtrl[1] && !fifoLocked[1]
    |-> ##2 !fifoLocked[1]) else $error("plain endpoint locked");
  chk_release_by_clear: assert property (
    $fell(fifoLocked[0]) |-> $past(clrHit, 2)) else $error("lock lost");
  cover property (wb_err_o);
  cover property ($fell(fifoLocked[0]));
  cover property (usbSetupHs && fifoLocked[0]);
endmodule // sofl_setup_lock_assertions
bind sofl_setup_lock sofl_setup_lock_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .usbEp(usbEp),
  .usbSetupTok(usbSetupTok), .usbSetupHs(usbSetupHs), .epIsCtrl(epIsCtrl),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .fifoLocked(fifoLocked));
`default_nettype wire

// >>> verif/sofl_usb_host.sv
`timescale 1ns/1ps
`default_nettype none
module sofl_usb_host (
  input  wire logic       sys_clk,
  output logic [1:0]      usbEp,
  output logic            usbSetupTok,
  output logic            usbSetupHs,
  output logic            usbDataWr,
  output logic            usbSeqToggle
);
  // Sequence tracking left to firmware writes in this model
  initial begin
    usbEp = 2'h0;
    usbSetupTok = 1'b0;
    usbSetupHs = 1'b0;
    usbDataWr = 1'b0;
    usbSeqToggle = 1'b0;
  end
  task automatic tok(input logic [1:0] e);
    usbEp <= e;
    usbSetupTok <= 1'b1;
    @(posedge sys_clk);
    usbSetupTok <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Each byte is followed by gap plus one idle cycles, so a large gap makes a slow host
  task automatic data(input int n, input int gap);
    repeat (n) begin
      usbDataWr <= 1'b1;
      @(posedge sys_clk);
      usbDataWr <= 1'b0;
      repeat (gap + 1) @(posedge sys_clk);
    end
  endtask
  task automatic hs();
    usbSetupHs <= 1'b1;
    @(posedge sys_clk);
    usbSetupHs <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule // sofl_usb_host
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        irq;
  logic [3:0]  locked;
  logic [1:0]  ep;
  logic        tok;
  logic        hs;
  logic        dwr;
  logic        tgl;
  logic [7:0]  q;
  logic        e;
  logic        clkEn;
  logic [3:0]  ctrlEp;
  logic [3:0]  sel;
  logic [3:0]  lanes;
  int          failCount;
  int          samplesChecked;
  int          cycles;
  sofl_setup_lock dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .usbEp(ep), .usbSetupTok(tok), .usbSetupHs(hs), .usbDataWr(dwr),
    .usbSeqToggle(tgl), .epIsCtrl(ctrlEp), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .irq(irq),
    .fifoLocked(locked));
  sofl_usb_host host (.sys_clk(sys_clk), .usbEp(ep), .usbSetupTok(tok),
    .usbSetupHs(hs), .usbDataWr(dwr), .usbSeqToggle(tgl));
  task automatic conclude();
    if (failCount == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] x);
    samplesChecked++;
    if (got !== x) begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge sys_clk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge sys_clk);
    q = rdat[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(q, x);
  endtask
  task automatic t_reset();
    rd(sofl_pkg::ADDR_STATUS, 8'h00);
    rd(sofl_pkg::ADDR_IRQST, 8'h00);
    bus(1'b0, 8'h00, 8'h00);
    chk({7'h00, e}, 8'h01);
  endtask
  task automatic t_lock();
    host.tok(2'h0);
    rd(sofl_pkg::ADDR_STATUS, 8'h20);
    host.data(3, 0);
    rd(sofl_pkg::ADDR_FIFO, 8'h00);
    host.hs();
    rd(sofl_pkg::ADDR_STATUS, 8'h10);
    chk({4'h0, locked}, 8'h01);
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h00);
    for (int i = 0; i < 5; i++) rd(sofl_pkg::ADDR_FIFO, 8'(i > 3 ? 3 : i));
  endtask
  task automatic t_again();
    host.tok(2'h0);
    host.data(2, 2);
    host.hs();
    rd(sofl_pkg::ADDR_FIFO, 8'h00);
    host.tok(2'h0);
    host.data(1, 0);
    host.hs();
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h10);
    rd(sofl_pkg::ADDR_STATUS, 8'h10);
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h00);
    rd(sofl_pkg::ADDR_FIFO, 8'h00);
    rd(sofl_pkg::ADDR_FIFO, 8'h01);
  endtask
  task automatic t_seq();
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h80);
    rd(sofl_pkg::ADDR_STATUS, 8'h00);
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h88);
    rd(sofl_pkg::ADDR_STATUS, 8'h80);
    host.tok(2'h0);
    rd(sofl_pkg::ADDR_STATUS, 8'h20);
    host.hs();
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h00);
  endtask
  task automatic t_plain();
    bus(1'b1, sofl_pkg::ADDR_INDEX, 8'h01);
    host.tok(2'h1);
    host.hs();
    rd(sofl_pkg::ADDR_STATUS, 8'h00);
    chk({4'h0, locked}, 8'h00);
    ctrlEp <= 4'h3;
    host.tok(2'h1);
    rd(sofl_pkg::ADDR_STATUS, 8'h20);
    host.hs();
    bus(1'b1, sofl_pkg::ADDR_STATUS, 8'h00);
    ctrlEp <= 4'h1;
    bus(1'b1, sofl_pkg::ADDR_INDEX, 8'h00);
  endtask
  task automatic t_irq();
    chk({7'h00, irq}, 8'h00);
    rd(sofl_pkg::ADDR_IRQST, 8'h03);
    bus(1'b1, sofl_pkg::ADDR_IRQMSK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, sofl_pkg::ADDR_IRQST, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rd(sofl_pkg::ADDR_IRQST, 8'h02);
  endtask
  task automatic t_freeze();
    clkEn <= 1'b0;
    host.tok(2'h0);
    host.hs();
    clkEn <= 1'b1;
    @(posedge sys_clk);
    chk({4'h0, locked}, 8'h00);
    rd(sofl_pkg::ADDR_STATUS, 8'h00);
    rd(sofl_pkg::ADDR_IRQST, 8'h02);
    lanes = 4'he;
    bus(1'b1, sofl_pkg::ADDR_INDEX, 8'h01);
    lanes = 4'hf;
    rd(sofl_pkg::ADDR_INDEX, 8'h00);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Whole run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      conclude();
    end
  end
  initial begin
    {rst_n, cyc, stb, we, adr, wdat} = '0;
    {clkEn, ctrlEp, sel, lanes} = {1'b1, 4'h1, 4'hf, 4'hf};
    {failCount, samplesChecked, cycles} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_lock();
    t_again();
    t_seq();
    t_plain();
    t_irq();
    t_freeze();
    conclude();
  end
endmodule // tb
`default_nettype wire

// >>> verilog/sofl_ep_state.sv
`timescale 1ns/1ps
`default_nettype none
module sofl_ep_state (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  input  wire logic                       isCtrl,
  input  wire logic                       setupTok,
  input  wire logic                       setupHs,
  input  wire logic                       dataWr,
  input  wire logic                       fwRead,
  input  wire logic                       clrEnd,
  input  wire logic                       seqWr,
  input  wire logic                       seqVal,
  input  wire logic                       seqToggle,
  output logic                            startFlag,
  output logic                            endFlag,
  output logic                            seqBit,
  output logic [sofl_pkg::PTR_W-1:0]      byteCount,
  output logic [sofl_pkg::PTR_W-1:0]      readPtr
);
  logic                       next_startFlag;
  logic                       next_endFlag;
  logic                       next_seqBit;
  logic [sofl_pkg::PTR_W-1:0] next_byteCount;
  logic [sofl_pkg::PTR_W-1:0] next_readPtr;
  logic                       locked;

  // Lock covers the whole overwrite window, start through end clear
  assign locked = startFlag | endFlag; // R4

  always_comb begin
    next_startFlag = startFlag;
    next_endFlag   = endFlag;
    next_seqBit    = seqBit;
    next_byteCount = byteCount;
    next_readPtr   = readPtr;
    if (clrEnd) begin
      next_endFlag = 1'b0; // R4
    end
    if (!locked && fwRead && readPtr != byteCount) begin
      next_readPtr = readPtr + sofl_pkg::PTR_ONE; // R5
    end
    if (dataWr) begin
      next_byteCount = byteCount + sofl_pkg::PTR_ONE;
    end
    if (seqWr) begin
      next_seqBit = seqVal; // R7
    end
    if (seqToggle) begin
      next_seqBit = ~seqBit;
    end
    if (setupTok && isCtrl) begin
      next_startFlag = 1'b1; // R6
      next_byteCount = sofl_pkg::PTR_ZERO; // R6
      next_readPtr   = sofl_pkg::PTR_ZERO; // R6
      next_seqBit    = 1'b0; // R7
    end
    if (setupHs && isCtrl) begin
      next_startFlag = 1'b0; // R6
      next_endFlag   = 1'b1; // R1 R2
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      startFlag <= 1'b0;
      endFlag   <= 1'b0;
      seqBit    <= 1'b0;
      byteCount <= sofl_pkg::PTR_ZERO;
      readPtr   <= sofl_pkg::PTR_ZERO;
    end else if (clkEn) begin
      startFlag <= next_startFlag;
      endFlag   <= next_endFlag;
      seqBit    <= next_seqBit;
      byteCount <= next_byteCount;
      readPtr   <= next_readPtr;
    end
  end
endmodule // sofl_ep_state
`default_nettype wire

// >>> verilog/sofl_setup_lock.sv
`timescale 1ns/1ps
`default_nettype none
module sofl_setup_lock (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         clkEn,
  // USB engine side, same clock
  input  wire logic [sofl_pkg::EP_W-1:0]    usbEp,
  input  wire logic                         usbSetupTok,
  input  wire logic                         usbSetupHs,
  input  wire logic                         usbDataWr,
  input  wire logic                         usbSeqToggle,
  input  wire logic [sofl_pkg::NUM_EP-1:0]  epIsCtrl,
  // Wishbone classic slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [sofl_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [sofl_pkg::DAT_W-1:0]   wb_dat_i,
  output logic [sofl_pkg::DAT_W-1:0]        wb_dat_o,
  output logic                              wb_ack_o,
  output logic                              wb_err_o,
  output logic                              irq,
  output logic [sofl_pkg::NUM_EP-1:0]       fifoLocked
);
  // ----------------------------------------------------------------
  // Per-endpoint state
  // ----------------------------------------------------------------
  logic [sofl_pkg::EP_W-1:0]   endpoint_select_index;
  logic [sofl_pkg::EP_W-1:0]   next_endpoint_select_index;
  logic [sofl_pkg::NUM_EP-1:0] startF;
  logic [sofl_pkg::NUM_EP-1:0] endF;
  logic [sofl_pkg::NUM_EP-1:0] seqF;
  logic [sofl_pkg::PTR_W-1:0]  rptr [sofl_pkg::NUM_EP];
  logic                        busReq;
  logic                        wrStb;
  logic                        rdStb;
  logic                        lane0;
  logic                        stWr;
  logic                        fifoRd;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // Writes land on the edge that sees ack, the one the master samples
  assign wrStb  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rdStb  = busReq & ~wb_we_i;
  // Status byte sits in the low lane of its word
  assign lane0  = wb_sel_i[0];
  assign stWr   = wrStb & lane0 & (wb_adr_i == sofl_pkg::ADDR_STATUS);
  // Reading the data word steps the selected endpoint's read pointer
  assign fifoRd = rdStb & (wb_adr_i == sofl_pkg::ADDR_FIFO);

  // ----------------------------------------------------------------
  // Endpoint instances
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < sofl_pkg::NUM_EP; g++) begin : gEp
      logic sel;
      logic hit;
      assign sel = (endpoint_select_index == sofl_pkg::EP_W'(g));
      assign hit = (usbEp == sofl_pkg::EP_W'(g));
      sofl_ep_state uEp (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .isCtrl    (epIsCtrl[g]),
        .setupTok  (usbSetupTok & hit),
        .setupHs   (usbSetupHs & hit), // R1
        .dataWr    (usbDataWr & hit),
        .fwRead    (fifoRd & sel), // R5
        // Writing zero to the end flag releases the lock
        .clrEnd    (stWr & sel & ~wb_dat_i[sofl_pkg::BIT_END]), // R3 R4
        .seqWr     (stWr & sel & wb_dat_i[sofl_pkg::BIT_SOVW]), // R7
        .seqVal    (wb_dat_i[sofl_pkg::BIT_SEQ]),
        .seqToggle (usbSeqToggle & hit),
        .startFlag (startF[g]),
        .endFlag   (endF[g]),
        .seqBit    (seqF[g]),
        // Count stays internal; only the pointer is visible
        .byteCount (),
        .readPtr   (rptr[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [sofl_pkg::IRQ_W-1:0] irqSt;
  logic [sofl_pkg::IRQ_W-1:0] irqMsk;
  logic [sofl_pkg::IRQ_W-1:0] next_irqSt;
  logic [sofl_pkg::IRQ_W-1:0] next_irqMsk;
  logic [sofl_pkg::IRQ_W-1:0] evt;
  logic                       next_irq;

  always_comb begin
    evt = '0;
    evt[sofl_pkg::IRQ_SETUP] = usbSetupTok;
    evt[sofl_pkg::IRQ_DONE]  = usbSetupHs;
    next_irqSt  = irqSt;
    next_irqMsk = irqMsk;
    if (wrStb && lane0 && wb_adr_i == sofl_pkg::ADDR_IRQST) begin
      next_irqSt = irqSt & ~wb_dat_i[sofl_pkg::IRQ_W-1:0];
    end
    if (wrStb && lane0 && wb_adr_i == sofl_pkg::ADDR_IRQMSK) begin
      next_irqMsk = wb_dat_i[sofl_pkg::IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_irqSt = next_irqSt | evt;
    // Built from next values so irq never lags its status bits
    next_irq   = |(next_irqSt & next_irqMsk);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSt  <= '0;
      irqMsk <= '0;
      irq    <= 1'b0;
    end else if (clkEn) begin
      irqSt  <= next_irqSt;
      irqMsk <= next_irqMsk;
      irq    <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint select and lock view
  // ----------------------------------------------------------------
  logic [sofl_pkg::NUM_EP-1:0] next_locked;

  always_comb begin
    next_endpoint_select_index = endpoint_select_index;
    if (wrStb && lane0 && wb_adr_i == sofl_pkg::ADDR_INDEX) begin
      next_endpoint_select_index = wb_dat_i[sofl_pkg::EP_W-1:0]; // R8
    end
    // Registered, so the view trails the flags by one cycle
    next_locked = startF | endF; // R4
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      endpoint_select_index    <= '0;
      fifoLocked <= '0;
    end else if (clkEn) begin
      endpoint_select_index    <= next_endpoint_select_index;
      fifoLocked <= next_locked;
    end
  end

  // ----------------------------------------------------------------
  // Status byte of the selected endpoint
  // ----------------------------------------------------------------
  logic [7:0] statusByte;

  always_comb begin
    statusByte = sofl_pkg::STATUS_RST;
    statusByte[sofl_pkg::BIT_SEQ]  = seqF[endpoint_select_index]; // R8
    statusByte[sofl_pkg::BIT_STRT] = startF[endpoint_select_index]; // R8
    statusByte[sofl_pkg::BIT_END]  = endF[endpoint_select_index]; // R8
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  logic [sofl_pkg::DAT_W-1:0] next_datO;
  logic                       next_ack;
  logic                       next_err;

  always_comb begin
    next_ack  = 1'b0;
    next_err  = 1'b0;
    next_datO = sofl_pkg::ZERO_WORD;
    if (busReq) begin
      unique case (wb_adr_i)
        sofl_pkg::ADDR_STATUS: begin
          next_ack = 1'b1;
          next_datO[7:0] = statusByte;
        end
        sofl_pkg::ADDR_INDEX: begin
          next_ack = 1'b1;
          next_datO[sofl_pkg::EP_W-1:0] = endpoint_select_index;
        end
        sofl_pkg::ADDR_IRQST: begin
          next_ack = 1'b1;
          next_datO[sofl_pkg::IRQ_W-1:0] = irqSt;
        end
        sofl_pkg::ADDR_IRQMSK: begin
          next_ack = 1'b1;
          next_datO[sofl_pkg::IRQ_W-1:0] = irqMsk;
        end
        sofl_pkg::ADDR_FIFO: begin
          // Pre-step pointer value; the step itself is in the endpoint
          next_ack = 1'b1;
          next_datO[sofl_pkg::PTR_W-1:0] = rptr[endpoint_select_index];
        end
        default: begin
          // Refused with no side effect, so a stray access never hangs
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= sofl_pkg::ZERO_WORD;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else if (clkEn) begin
      wb_dat_o <= next_datO;
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
    end
  end
endmodule // sofl_setup_lock
`default_nettype wire
